// *** tb/ddl_link_sva.sv ***
// Checker of the link wires and converter outputs of the dual converter input path.
`timescale 1ns/1ns
module ddl_link_sva
  import ddl_pkg::*;
(
  input wire logic      clk_sys,                    // System clock.
  input wire logic      rst,                        // Reset, high.
  input wire ddl_code_t chanAData,                  // Channel A word.
  input wire logic      chan_a_input_latch_strobe,  // Channel A strobe.
  input wire logic      chan_a_update_clock,        // Channel A update.
  input wire logic      chan_b_input_latch_strobe,  // Channel B strobe.
  input wire logic      chan_b_update_clock,        // Channel B update.
  input wire logic      sleep_request,              // Power-down pin.
  input wire logic      gain_resistor_mode_select,  // Gain mode pin.
  input wire ddl_code_t chan_a_true_current_out,    // Channel A code.
  input wire ddl_code_t chanAComplementOut,         // Channel A complement.
  input wire ddl_code_t chan_b_true_current_out,    // Channel B code.
  input wire ddl_code_t chanBComplementOut,         // Channel B complement.
  input wire logic      sleepActive,                // Powered down.
  input wire logic      gainSingleResistor          // One resistor.
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // A tied strobe and clock can never let the update edge lag the strobe edge.
  AST_A_TIED: assert property (chan_a_input_latch_strobe == chan_a_update_clock)
    else $error("channel A update clock differs from its strobe");
  AST_B_TIED: assert property (chan_b_input_latch_strobe == chan_b_update_clock)
    else $error("channel B update clock differs from its strobe");
  // The bench runs two cycles a half period, which keeps the rate limit.
  AST_DUTY: assert property ($rose(chan_a_input_latch_strobe) |->
    chan_a_input_latch_strobe[*2] ##1 !chan_a_input_latch_strobe)
    else $error("strobe high phase is not two cycles");
  AST_DATA_HELD: assert property ($rose(chan_a_input_latch_strobe) |=> $stable(chanAData))
    else $error("channel A word moved while being captured");
  // Outputs move only three cycles after an update edge, and hold otherwise.
  AST_A_HOLD: assert property ($changed(chan_a_true_current_out) |->
    $past(chan_a_update_clock, 3) && !$past(chan_a_update_clock, 4))
    else $error("channel A output changed without an update edge");
  AST_B_HOLD: assert property ($changed(chan_b_true_current_out) |->
    $past(chan_b_update_clock, 3) && !$past(chan_b_update_clock, 4))
    else $error("channel B output changed without an update edge");
  AST_A_COMPL: assert property (chanAComplementOut == 14'h3FFF - chan_a_true_current_out)
    else $error("channel A complement wrong");
  AST_B_COMPL: assert property (chanBComplementOut == 14'h3FFF - chan_b_true_current_out)
    else $error("channel B complement wrong");
  AST_SLEEP: assert property (sleepActive == $past(sleep_request, 3))
    else $error("sleep state does not follow its pin");
  AST_GAIN: assert property (gainSingleResistor == $past(gain_resistor_mode_select, 3))
    else $error("gain mode does not follow its pin");
  // Main scenarios reached.
  cover property ($rose(chan_a_update_clock));
  cover property (sleepActive && gainSingleResistor);
  cover property (chan_a_true_current_out == 14'h3FFF);
endmodule

// *** tb/dual_dac_double_latch_input_bench.sv ***
// Self-checking bench joining the source and converter ends through the link.
`timescale 1ns/1ns
module dual_dac_double_latch_input_bench;
  import ddl_pkg::*;
  logic        clk_sys;
  logic        rst;
  ddl_code_t   sampleA;
  ddl_code_t   sampleB;
  logic        sampleValid;
  logic        sampleReady;
  logic        sleepIn;
  logic        gainOneIn;
  ddl_code_t   outA;
  ddl_code_t   cmpA;
  ddl_code_t   outB;
  ddl_code_t   cmpB;
  logic        sleepActive;
  logic        gainSingleResistor;
  logic [27:0] expQ[$];
  logic [31:0] seed;
  int          errCount;
  int          checked;

  ddl_link_if link();
  ddl_source #(.HALF(2)) u_ddl_source (.clk_sys, .rst, .sampleA, .sampleB, .sampleValid,
    .sampleReady, .sleepIn, .gainOneIn, .link(link));
  ddl_converter u_ddl_converter (.clk_sys, .rst, .link(link), .chan_a_true_current_out(outA),
    .chanAComplementOut(cmpA), .chan_b_true_current_out(outB), .chanBComplementOut(cmpB),
    .sleepActive, .gainSingleResistor);
  ddl_link_sva u_ddl_link_sva (.clk_sys, .rst, .chanAData(link.chanAData),
    .chan_a_input_latch_strobe(link.chan_a_input_latch_strobe),
    .chan_a_update_clock(link.chan_a_update_clock),
    .chan_b_input_latch_strobe(link.chan_b_input_latch_strobe),
    .chan_b_update_clock(link.chan_b_update_clock), .sleep_request(link.sleep_request),
    .gain_resistor_mode_select(link.gain_resistor_mode_select),
    .chan_a_true_current_out(outA), .chanAComplementOut(cmpA),
    .chan_b_true_current_out(outB), .chanBComplementOut(cmpB), .sleepActive,
    .gainSingleResistor);

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string what, input logic [27:0] seen, input logic [27:0] exp);
    checked++;
    if (seen !== exp) begin
      errCount++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Free-running 100 MHz system clock.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Sampled at the falling edge so the link flops have settled; an update edge loads the
  // word forwarded one strobe earlier, visible three cycles on.
  initial begin
    logic        prev;
    logic [27:0] w;
    prev = 1'b0;
    forever begin
      @(negedge clk_sys);
      if (!rst && link.chan_a_update_clock === 1'b1 && prev === 1'b0) begin
        repeat (3) @(negedge clk_sys);
        w = (expQ.size() > 0) ? expQ.pop_front() : 28'hXXXXXXX;
        chk("codes", {outA, outB}, w);
        chk("complements", {cmpA, cmpB}, {14'h3FFF - w[27:14], 14'h3FFF - w[13:0]});
      end
      prev = link.chan_a_update_clock;
    end
  end

  // Main sequence: controls, then a stream that overruns the buffer.
  initial begin
    int          k;
    int          refused;
    logic [27:0] w;
    seed = 32'h00012035;
    errCount = 0;
    checked = 0;
    refused = 0;
    rst = 1'b1;
    sampleA = 14'h0000;
    sampleB = 14'h0000;
    sampleValid = 1'b0;
    sleepIn = 1'b0;
    gainOneIn = 1'b0;
    expQ.push_back(28'h0000000);
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    for (k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      sleepIn <= k[0];
      gainOneIn <= k[1];
      repeat (5) @(posedge clk_sys);
      #1;
      chk("sleep", 28'(sleepActive), 28'(k[0]));
      chk("gain", 28'(gainSingleResistor), 28'(k[1]));
    end
    $display("test controls done");
    @(posedge clk_sys);
    sleepIn <= 1'b0;
    gainOneIn <= 1'b0;
    // Full scale, zero and split words first, then random pairs back to back.
    for (k = 0; k < 40; k++) begin
      w = (k == 0) ? 28'hFFFFFFF : (k == 1) ? 28'h0000000 : (k == 2) ? 28'hFFFC000 : 28'(rnd());
      {sampleA, sampleB} <= w;
      sampleValid <= 1'b1;
      @(negedge clk_sys);
      while (sampleReady !== 1'b1 && refused < 5000) begin
        refused++;
        @(negedge clk_sys);
      end
      if (refused >= 5000) begin
        errCount++;
        wrapUp();
      end
      expQ.push_back(w);
      @(posedge clk_sys);
    end
    sampleValid <= 1'b0;
    chk("refused", 28'(refused > 0), 28'h1);
    // The last word waits in the forwarding stage until another update edge comes.
    k = 0;
    while (expQ.size() > 1 && k < 2000) begin
      @(posedge clk_sys);
      k++;
    end
    chk("drained", 28'(expQ.size()), 28'h1);
    $display("test stream done");
    wrapUp();
  end
endmodule

// *** verilog/ddl_converter.sv ***
// Converter end: double latch per channel, sampled on the system clock.
`timescale 1ns/1ns
module ddl_converter
  import ddl_pkg::*;
(
  input  wire logic clk_sys,                   // System clock.
  input  wire logic rst,                       // Asynchronous reset, high.
  ddl_link_if.converter link,                  // Link from source.
  output ddl_code_t chan_a_true_current_out,   // Channel A code.
  output ddl_code_t chanAComplementOut,        // Channel A complement code.
  output ddl_code_t chan_b_true_current_out,   // Channel B code.
  output ddl_code_t chanBComplementOut,        // Channel B complement code.
  output logic      sleepActive,               // Converter powered down.
  output logic      gainSingleResistor         // One resistor sets both gains.
);
  localparam int unsigned NS = 4 + 2 * DATA_W + 2;
  logic [NS-1:0]   sync1_q;
  logic [NS-1:0]   sync2_q;
  logic [1:0]      wrPrev_q;
  logic [1:0]      ckPrev_q;
  ddl_code_t       inLat_q [2];
  ddl_code_t       fwd_q [2];
  ddl_code_t       dacLat_q [2];
  ddl_code_t       cmpLat_q [2];
  logic            slp_q;
  logic            gainMode_q;
  logic [1:0]      wrS;
  logic [1:0]      ckS;
  ddl_code_t       dS [2];

  // Pins come from outside, so each passes two flops before use.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      // Channel B sits above channel A in the strobe and clock pairs, so bit c is channel c; channel A data sits above channel B data.
      sync1_q <= {link.chan_b_input_latch_strobe, link.chan_a_input_latch_strobe,
                  link.chan_b_update_clock, link.chan_a_update_clock,
                  link.chanAData, link.chanBData,
                  link.sleep_request, link.gain_resistor_mode_select};
      sync2_q <= sync1_q;
    end
  end
  // Data is stable a half period before the strobe, so word skew is harmless.
  assign wrS   = sync2_q[NS-1 -: 2];
  assign ckS   = sync2_q[NS-3 -: 2];
  assign dS[0] = sync2_q[NS-5 -: DATA_W];
  assign dS[1] = sync2_q[NS-5-DATA_W -: DATA_W];

  // Edge history per channel.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPrev_q <= 2'h0;
      ckPrev_q <= 2'h0;
    end else begin
      wrPrev_q <= wrS;
      ckPrev_q <= ckS;
    end
  end

  // Each channel runs its own double latch; no term crosses channels.
  for (genvar c = 0; c < 2; c++) begin : gChan
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        inLat_q[c]  <= CODE_RESET;
        fwd_q[c]    <= CODE_RESET;
        dacLat_q[c] <= CODE_RESET;
        cmpLat_q[c] <= CODE_FULL;
      end else begin
        if (wrS[c] && !wrPrev_q[c]) begin
          inLat_q[c] <= dS[c];
        end
        if (!wrS[c] && wrPrev_q[c]) begin
          fwd_q[c] <= inLat_q[c];
        end
        // Tied clock and strobe load the word forwarded one period earlier.
        if (ckS[c] && !ckPrev_q[c]) begin
          dacLat_q[c] <= fwd_q[c];
          cmpLat_q[c] <= ddl_complement(fwd_q[c]);
        end
      end
    end
  end

  // Static controls; reset low matches the pull-down default.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slp_q      <= 1'b0;
      gainMode_q <= 1'b0;
    end else begin
      slp_q      <= sync2_q[1];
      gainMode_q <= sync2_q[0];
    end
  end

  // Complement codes have their own flops, so every output comes from a register.
  assign chan_a_true_current_out = dacLat_q[0];
  assign chanAComplementOut      = cmpLat_q[0];
  assign chan_b_true_current_out = dacLat_q[1];
  assign chanBComplementOut      = cmpLat_q[1];
  assign sleepActive             = slp_q;
  assign gainSingleResistor      = gainMode_q;
endmodule

// *** verilog/ddl_fifo.sv ***
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module ddl_fifo #(
  parameter int unsigned WIDTH = 28,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_sys,   // System clock.
  input  wire logic             rst,       // Asynchronous reset, high.
  input  wire logic [WIDTH-1:0] inData,    // Write word.
  input  wire logic             inValid,   // Write request.
  output logic                  inReady,   // Room available.
  output logic      [WIDTH-1:0] outData,   // Head word.
  output logic                  outValid,  // Head word present.
  input  wire logic             outReady   // Consumer takes head.
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic [AW:0]      countNext;
  logic             doWr;
  logic             doRd;

  // Flags are registered from the next count, so full and empty stay exact.
  assign outData   = mem[rdPtr_q];
  assign doWr      = inValid && inReady;
  assign doRd      = outValid && outReady;
  assign countNext = count_q + (AW+1)'(doWr) - (AW+1)'(doRd);

  // Storage array has no reset; only pointers, count and flags need a defined state.
  always_ff @(posedge clk_sys) begin
    if (doWr) begin
      mem[wrPtr_q] <= inData;
    end
  end

  // Pointers wrap at the depth, which is taken as a power of two.
  // Flags cost a compare on the next count but leave both ports glitch free.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPtr_q  <= '0;
      rdPtr_q  <= '0;
      count_q  <= '0;
      inReady  <= 1'b1;
      outValid <= 1'b0;
    end else begin
      if (doWr) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (doRd) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      count_q  <= countNext;
      inReady  <= (countNext != (AW+1)'(DEPTH));
      outValid <= (countNext != '0);
    end
  end
endmodule

// *** verilog/ddl_link_if.sv ***
// Interface carrying the parallel ports and static controls between source and converter.
`timescale 1ns/1ns
interface ddl_link_if;
  import ddl_pkg::*;
  ddl_code_t chanAData;
  ddl_code_t chanBData;
  logic      chan_a_input_latch_strobe;
  logic      chan_b_input_latch_strobe;
  logic      chan_a_update_clock;
  logic      chan_b_update_clock;
  logic      sleep_request;
  logic      gain_resistor_mode_select;

  modport source (
    output chanAData, chanBData,
    output chan_a_input_latch_strobe, chan_b_input_latch_strobe,
    output chan_a_update_clock, chan_b_update_clock,
    output sleep_request, gain_resistor_mode_select
  );
  modport converter (
    input chanAData, chanBData,
    input chan_a_input_latch_strobe, chan_b_input_latch_strobe,
    input chan_a_update_clock, chan_b_update_clock,
    input sleep_request, gain_resistor_mode_select
  );
endinterface

// *** verilog/ddl_pkg.sv ***
// Package with constants and types shared by both ends of the dual converter input link.
package ddl_pkg;
  localparam int unsigned DATA_W         = 14;
  localparam int unsigned FIFO_DEPTH     = 16;
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned MAX_RATE_MSPS  = 125;
  // Shortest sample period in ns, rounded up to whole ns.
  localparam int unsigned MIN_SAMPLE_NS  = (1000 + MAX_RATE_MSPS - 1) / MAX_RATE_MSPS;
  // Half period of the link strobe in system cycles, at least one cycle.
  localparam int unsigned HALF_CYC_MIN   = (MIN_SAMPLE_NS + 2 * CLK_PERIOD_NS - 1)
                                           / (2 * CLK_PERIOD_NS);
  localparam int unsigned HALF_CYC       = (HALF_CYC_MIN < 1) ? 1 : HALF_CYC_MIN;
  localparam logic [13:0] CODE_RESET     = 14'h0000;
  localparam logic [13:0] CODE_FULL      = 14'h3FFF;
  localparam logic [7:0]  DIV_RESET      = 8'h00;

  typedef logic [DATA_W-1:0] ddl_code_t;
  typedef enum logic [1:0] {
    DDL_IDLE,
    DDL_HIGH,
    DDL_LOW
  } ddl_phase_t;

  // Complementary output code: full scale when every input bit is zero.
  function automatic ddl_code_t ddl_complement(input ddl_code_t code);
    return CODE_FULL - code;
  endfunction
endpackage

// *** verilog/ddl_source.sv ***
// Sample source end: buffers sample pairs and drives both channel ports and controls.
`timescale 1ns/1ns
module ddl_source
  import ddl_pkg::*;
#(
  parameter int unsigned HALF = HALF_CYC
) (
  input  wire logic      clk_sys,      // System clock.
  input  wire logic      rst,          // Asynchronous reset, high.
  input  wire ddl_code_t sampleA,      // Channel A sample.
  input  wire ddl_code_t sampleB,      // Channel B sample.
  input  wire logic      sampleValid,  // Sample pair offered.
  output logic           sampleReady,  // Buffer has room.
  input  wire logic      sleepIn,      // Power-down wanted.
  input  wire logic      gainOneIn,    // Single resistor gain wanted.
  ddl_link_if.source     link          // Link to converter.
);
  logic [2*DATA_W-1:0] headData;
  logic                headValid;
  logic                take;
  ddl_phase_t          phase_q;
  logic [7:0]          div_q;
  logic                tick;
  ddl_code_t           aData_q;
  ddl_code_t           bData_q;
  logic                strobe_q;
  logic                sleep_q;
  logic                gain_q;

  ddl_fifo #(.WIDTH(2*DATA_W), .DEPTH(FIFO_DEPTH)) uFifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .inData   ({sampleA, sampleB}),
    .inValid  (sampleValid),
    .inReady  (sampleReady),
    .outData  (headData),
    .outValid (headValid),
    .outReady (take)
  );

  // Divider gives one enable per half strobe period, keeping the rate legal.
  assign tick = (div_q == 8'(HALF - 1));
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_q <= DIV_RESET;
    end else if (tick) begin
      div_q <= DIV_RESET;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // A word is taken only at the start of a strobe period.
  assign take = tick && (phase_q != DDL_HIGH) && headValid;

  // One shared strobe drives write strobe and update clock together.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_q  <= DDL_IDLE;
      strobe_q <= 1'b0;
      aData_q  <= CODE_RESET;
      bData_q  <= CODE_RESET;
    end else if (tick) begin
      case (phase_q)
        DDL_IDLE, DDL_LOW: begin
          if (headValid) begin
            // Data set up one half period before the rising edge.
            aData_q  <= headData[2*DATA_W-1:DATA_W];
            bData_q  <= headData[DATA_W-1:0];
            phase_q  <= DDL_HIGH;
          end else begin
            phase_q  <= DDL_IDLE;
          end
          strobe_q <= 1'b0;
        end
        DDL_HIGH: begin
          // Equal high and low halves give a symmetric duty cycle.
          strobe_q <= 1'b1;
          phase_q  <= DDL_LOW;
        end
        default: begin
          phase_q  <= DDL_IDLE;
          strobe_q <= 1'b0;
        end
      endcase
    end
  end

  // Static controls are registered so every output comes from a flip-flop.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sleep_q <= 1'b0;
      gain_q  <= 1'b0;
    end else begin
      sleep_q <= sleepIn;
      gain_q  <= gainOneIn;
    end
  end

  // Clock and strobe share one flop, so their lead is zero.
  assign link.chanAData                 = aData_q;
  assign link.chanBData                 = bData_q;
  assign link.chan_a_input_latch_strobe = strobe_q;
  assign link.chan_b_input_latch_strobe = strobe_q;
  assign link.chan_a_update_clock       = strobe_q;
  assign link.chan_b_update_clock       = strobe_q;
  assign link.sleep_request             = sleep_q;
  assign link.gain_resistor_mode_select = gain_q;
endmodule
